// >>> verilog/cmpbk_pkg.sv
// Package: register map, field positions and reset values of the comparator register bank
package cmpbk_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam int unsigned NUM_CMP = 2;
  localparam logic [7:0] CTRL0_OFS   = 8'h00;
  localparam logic [7:0] CTRL_STRIDE = 8'h10;
  localparam logic [7:0] STAT_OFS    = 8'h20;
  localparam logic [7:0] IRQ_ST_OFS  = 8'h30;
  localparam logic [7:0] IRQ_MSK_OFS = 8'h34;
  localparam logic [1:0] ALIAS_BASE  = 2'h0;
  localparam logic [1:0] ALIAS_CLR   = 2'h1;
  localparam logic [1:0] ALIAS_SET   = 2'h2;
  localparam logic [1:0] ALIAS_INV   = 2'h3;

  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int unsigned ON_BIT    = 15;
  localparam int unsigned OE_BIT    = 14;
  localparam int unsigned INV_BIT   = 13;
  localparam int unsigned RES_BIT   = 8;
  localparam int unsigned EVS_LSB   = 6;
  localparam int unsigned PSEL_BIT  = 4;
  localparam int unsigned NSEL_LSB  = 0;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_E0D3;
  localparam logic [31:0] CTRL_RST   = 32'h0000_00C3;

  // ==========================================================================
  // Shared status register fields
  // ==========================================================================
  localparam int unsigned FRZ_BIT  = 14;
  localparam int unsigned IDLE_BIT = 13;
  localparam logic [31:0] STAT_WMASK = 32'h0000_6000;
  localparam logic [31:0] STAT_RST   = 32'h0000_0000;

  // Event edge select encodings
  localparam logic [1:0] EVS_NONE = 2'h0;
  localparam logic [1:0] EVS_RISE = 2'h1;
  localparam logic [1:0] EVS_FALL = 2'h2;
  localparam logic [1:0] EVS_BOTH = 2'h3;

endpackage

// >>> verilog/cmpbk_top.sv
// Comparator register bank: control, shared status, alias writes and events
`timescale 1ns/10ps

// How it works
// - Clear alias at +4 clears written bits
// - Set alias at +8 sets written bits
// - Invert alias at +C toggles written bits
// - Unimplemented bits read zero, ignore writes
// - Invert bit flips comparator result
// - Input selects pick pin or reference
module cmpbk_top (
  input  wire logic        clk_sys_i,     // System clock, 20 MHz
  input  wire logic        arst_n_i,      // Async reset, active low
  input  wire logic [7:0]  addr_i,        // Byte address
  input  wire logic [31:0] wdata_i,       // Write data
  input  wire logic        wr_i,          // Write strobe
  input  wire logic        rd_i,          // Read strobe
  output logic      [31:0] rdata_o,       // Read data, cycle after strobe
  input  wire logic [1:0]  raw_result_i,  // Analog comparator raw results
  output logic      [1:0]  result_o,      // Polarity-adjusted results
  output logic      [1:0]  pin_out_o,     // Output pin values
  output logic      [1:0]  pin_oe_o,      // Output pin enables
  output logic      [1:0]  enable_o,      // Comparator enables
  output logic      [1:0]  pos_sel_o,     // Positive input select per comparator
  output logic      [3:0]  neg_sel_o,     // Negative input select, 2 bits each
  output logic             freeze_o,      // Debug halt freeze control
  output logic             idle_stop_o,   // Stop in idle control
  output logic             irq_o          // Level interrupt
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic [31:0] ctrl_r [2];
  logic [31:0] ctrl_nxt [2];
  logic [31:0] stat_r, stat_nxt;
  logic [1:0]  irq_st_r, irq_st_nxt;
  logic [1:0]  irq_msk_r, irq_msk_nxt;
  logic [1:0]  res_prev_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  result;
  logic [1:0]  edge_evt;

  // Alias arithmetic shared by every aliased register
  function automatic logic [31:0] cmpbk_alias(input logic [31:0] cur, input logic [31:0] wd,
                                              input logic [1:0] kind, input logic [31:0] wm);
    logic [31:0] v;
    v = cur;
    unique case (kind)
      cmpbk_pkg::ALIAS_BASE: v = wd;
      cmpbk_pkg::ALIAS_CLR:  v = cur & ~wd;
      cmpbk_pkg::ALIAS_SET:  v = cur | wd;
      cmpbk_pkg::ALIAS_INV:  v = cur ^ wd;
    endcase
    return (v & wm) | (cur & ~wm);
  endfunction

  // ==========================================================================
  // Result path
  // ==========================================================================
  // Disabled comparator reads as zero so a stale analog level cannot raise events
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      result[i] = ctrl_r[i][cmpbk_pkg::ON_BIT] &
                  (raw_result_i[i] ^ ctrl_r[i][cmpbk_pkg::INV_BIT]);
    end
  end

  // Edge events per selected polarity
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      unique case (ctrl_r[i][cmpbk_pkg::EVS_LSB +: 2])
        cmpbk_pkg::EVS_NONE: edge_evt[i] = 1'b0;
        cmpbk_pkg::EVS_RISE: edge_evt[i] = result[i] & ~res_prev_r[i];
        cmpbk_pkg::EVS_FALL: edge_evt[i] = ~result[i] & res_prev_r[i];
        cmpbk_pkg::EVS_BOTH: edge_evt[i] = result[i] ^ res_prev_r[i];
      endcase
    end
  end

  // ==========================================================================
  // Register writes
  // ==========================================================================
  always_comb begin
    logic [7:0] base;
    base = 8'h00;
    for (int i = 0; i < 2; i++) begin
      ctrl_nxt[i] = ctrl_r[i];
      base = cmpbk_pkg::CTRL0_OFS + 8'(i * 16);
      if (wr_i && addr_i[7:4] == base[7:4] && addr_i[1:0] == 2'h0) begin
        ctrl_nxt[i] = cmpbk_alias(ctrl_r[i], wdata_i, addr_i[3:2], cmpbk_pkg::CTRL_WMASK);
      end
    end
    stat_nxt = stat_r;
    if (wr_i && addr_i[7:4] == cmpbk_pkg::STAT_OFS[7:4] && addr_i[1:0] == 2'h0) begin
      stat_nxt = cmpbk_alias(stat_r, wdata_i, addr_i[3:2], cmpbk_pkg::STAT_WMASK);
    end
    irq_msk_nxt = irq_msk_r;
    if (wr_i && addr_i == cmpbk_pkg::IRQ_MSK_OFS) begin
      irq_msk_nxt = wdata_i[1:0];
    end
    // Set wins over write-one-to-clear so no edge is lost
    irq_st_nxt = irq_st_r;
    if (wr_i && addr_i == cmpbk_pkg::IRQ_ST_OFS) begin
      irq_st_nxt = irq_st_r & ~wdata_i[1:0];
    end
    irq_st_nxt = irq_st_nxt | edge_evt;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r[0]  <= cmpbk_pkg::CTRL_RST;
      ctrl_r[1]  <= cmpbk_pkg::CTRL_RST;
      stat_r     <= cmpbk_pkg::STAT_RST;
      irq_st_r   <= 2'h0;
      irq_msk_r  <= 2'h0;
      res_prev_r <= 2'h0;
    end else begin
      ctrl_r[0]  <= ctrl_nxt[0];
      ctrl_r[1]  <= ctrl_nxt[1];
      stat_r     <= stat_nxt;
      irq_st_r   <= irq_st_nxt;
      irq_msk_r  <= irq_msk_nxt;
      res_prev_r <= result;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  // Alias reads return zero; software is told to disregard them anyway
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_i && addr_i[1:0] == 2'h0 && addr_i[3:2] == cmpbk_pkg::ALIAS_BASE) begin
      if (addr_i[7:4] == cmpbk_pkg::CTRL0_OFS[7:4]) begin
        rdata_nxt = (ctrl_r[0] & cmpbk_pkg::CTRL_WMASK) |
                    (32'(result[0]) << cmpbk_pkg::RES_BIT);
      end else if (addr_i[7:4] == cmpbk_pkg::CTRL_STRIDE[7:4]) begin
        rdata_nxt = (ctrl_r[1] & cmpbk_pkg::CTRL_WMASK) |
                    (32'(result[1]) << cmpbk_pkg::RES_BIT);
      end else if (addr_i[7:4] == cmpbk_pkg::STAT_OFS[7:4]) begin
        rdata_nxt = (stat_r & cmpbk_pkg::STAT_WMASK) | {30'h0, result};
      end
    end
    if (rd_i && addr_i == cmpbk_pkg::IRQ_ST_OFS) begin
      rdata_nxt = {30'h0, irq_st_r};
    end
    if (rd_i && addr_i == cmpbk_pkg::IRQ_MSK_OFS) begin
      rdata_nxt = {30'h0, irq_msk_r};
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rdata_o = rdata_r;
  assign result_o = result;
  assign irq_o = |(irq_st_r & irq_msk_r);
  assign freeze_o = stat_r[cmpbk_pkg::FRZ_BIT];
  assign idle_stop_o = stat_r[cmpbk_pkg::IDLE_BIT];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      enable_o[i]         = ctrl_r[i][cmpbk_pkg::ON_BIT];
      pin_oe_o[i]         = ctrl_r[i][cmpbk_pkg::ON_BIT] & ctrl_r[i][cmpbk_pkg::OE_BIT];
      pin_out_o[i]        = result[i] & pin_oe_o[i];
      pos_sel_o[i]        = ctrl_r[i][cmpbk_pkg::PSEL_BIT];
      neg_sel_o[2*i +: 2] = ctrl_r[i][cmpbk_pkg::NSEL_LSB +: 2];
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_clr_wr;
    wr_i && addr_i == 8'h04;
  endsequence

  a_clr_alias: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_clr_wr |=> ((ctrl_r[0] & $past(wdata_i) & cmpbk_pkg::CTRL_WMASK) == 32'h0))
    else $error("clear alias left bits set");
  a_set_alias: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_i && addr_i == 8'h08 |=> ((~ctrl_r[0] & $past(wdata_i) & cmpbk_pkg::CTRL_WMASK) == 32'h0))
    else $error("set alias left bits clear");
  a_inv_alias: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_i && addr_i == 8'h1C |=> ctrl_r[1] == (($past(ctrl_r[1]) ^ ($past(wdata_i) & cmpbk_pkg::CTRL_WMASK))))
    else $error("invert alias wrong");
  a_unimpl_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_i && addr_i == 8'h00 |=> (rdata_o & ~32'h0000_E1D3) == 32'h0)
    else $error("unimplemented bits nonzero");
  a_polarity: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ctrl_r[0][cmpbk_pkg::ON_BIT] |-> result_o[0] == (raw_result_i[0] ^ ctrl_r[0][cmpbk_pkg::INV_BIT]))
    else $error("polarity wrong");
  a_input_sel: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_i && addr_i == 8'h10 |=> neg_sel_o[3:2] == $past(wdata_i[1:0]) && pos_sel_o[1] == $past(wdata_i[4]))
    else $error("input select not applied");
  a_result_ro: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_i && addr_i == 8'h20 |=> rdata_o[1:0] == $past(result))
    else $error("result mirror wrong");
  a_irq_sticky: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    edge_evt[0] |=> irq_st_r[0])
    else $error("event lost");

  // ==========================================================================
  // Alias coverage of the second comparator, the invert alias of the first comparator and the shared status
  // ==========================================================================
  // Each alias is a one-cycle write; the effect must be visible next cycle
  sequence s_ctrl1_clr_wr;
    wr_i && addr_i == 8'h14;
  endsequence

  sequence s_ctrl1_set_wr;
    wr_i && addr_i == 8'h18;
  endsequence

  sequence s_stat_clr_wr;
    wr_i && addr_i == 8'h24;
  endsequence

  sequence s_stat_set_wr;
    wr_i && addr_i == 8'h28;
  endsequence

  sequence s_stat_inv_wr;
    wr_i && addr_i == 8'h2C;
  endsequence

  a_clr_ctrl1: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_ctrl1_clr_wr |=> ((ctrl_r[1] & $past(wdata_i) & cmpbk_pkg::CTRL_WMASK) == 32'h0))
    else $error("clear alias of second control left bits set");

  a_set_ctrl1: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_ctrl1_set_wr |=> ((~ctrl_r[1] & $past(wdata_i) & cmpbk_pkg::CTRL_WMASK) == 32'h0))
    else $error("set alias of second control left bits clear");

  a_inv_ctrl0: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_i && addr_i == 8'h0C |=> ctrl_r[0] == ($past(ctrl_r[0]) ^ ($past(wdata_i) & cmpbk_pkg::CTRL_WMASK)))
    else $error("invert alias of first control wrong");

  a_clr_stat: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_stat_clr_wr |=> ((stat_r & $past(wdata_i) & cmpbk_pkg::STAT_WMASK) == 32'h0))
    else $error("clear alias of status left bits set");

  a_set_stat: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_stat_set_wr |=> ((~stat_r & $past(wdata_i) & cmpbk_pkg::STAT_WMASK) == 32'h0))
    else $error("set alias of status left bits clear");

  a_inv_stat: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_stat_inv_wr |=> stat_r == ($past(stat_r) ^ ($past(wdata_i) & cmpbk_pkg::STAT_WMASK)))
    else $error("invert alias of status wrong");

  // ==========================================================================
  // Reads: alias, idle and unimplemented bits; stored copies and misaligned writes
  // ==========================================================================
  // Alias reads carry nothing; returning zero keeps software from trusting them
  sequence s_alias_rd;
    rd_i && addr_i[1:0] == 2'h0 && addr_i[3:2] != cmpbk_pkg::ALIAS_BASE && addr_i[7:4] < 4'h3;
  endsequence

  a_alias_rd_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    s_alias_rd |=> rdata_o == 32'h0)
    else $error("alias read returned data");

  a_rd_idle_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !rd_i |=> rdata_o == 32'h0)
    else $error("read data outside its cycle");

  a_ctrl1_unimpl: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_i && addr_i == 8'h10 |=> (rdata_o & ~32'h0000_E1D3) == 32'h0)
    else $error("second control unimplemented bits nonzero");

  a_stat_unimpl: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_i && addr_i == 8'h20 |=> (rdata_o & ~32'h0000_6003) == 32'h0)
    else $error("status unimplemented bits nonzero");

  // Stored copies must never pick up bits outside the writable mask
  a_ctrl0_store: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (ctrl_r[0] & ~cmpbk_pkg::CTRL_WMASK) == 32'h0)
    else $error("first control stored an unimplemented bit");

  a_ctrl1_store: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (ctrl_r[1] & ~cmpbk_pkg::CTRL_WMASK) == 32'h0)
    else $error("second control stored an unimplemented bit");

  a_stat_store: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (stat_r & ~cmpbk_pkg::STAT_WMASK) == 32'h0)
    else $error("status stored an unimplemented bit");

  // A misaligned write must leave both control registers and the status register alone
  a_misaligned: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_i && addr_i[1:0] != 2'h0 |=> ctrl_r[0] == $past(ctrl_r[0]) && ctrl_r[1] == $past(ctrl_r[1]) &&
                                    stat_r == $past(stat_r))
    else $error("misaligned write changed a register");

  // ==========================================================================
  // Result, polarity and input selection
  // ==========================================================================
  a_polarity1: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    ctrl_r[1][cmpbk_pkg::ON_BIT] |-> result_o[1] == (raw_result_i[1] ^ ctrl_r[1][cmpbk_pkg::INV_BIT]))
    else $error("second polarity wrong");

  a_off_quiet: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !ctrl_r[0][cmpbk_pkg::ON_BIT] |-> !result_o[0] && !pin_out_o[0])
    else $error("disabled comparator drives a result");

  a_input_sel0: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wr_i && addr_i == 8'h00 |=> neg_sel_o[1:0] == $past(wdata_i[1:0]) && pos_sel_o[0] == $past(wdata_i[4]))
    else $error("first input select not applied");

  a_result_rd0: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_i && addr_i == 8'h00 |=> rdata_o[cmpbk_pkg::RES_BIT] == $past(result[0]))
    else $error("first result bit wrong");

  a_result_rd1: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    rd_i && addr_i == 8'h10 |=> rdata_o[cmpbk_pkg::RES_BIT] == $past(result[1]))
    else $error("second result bit wrong");

  // Result bit is never stored, so no write can fake it
  a_result_nowr: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !ctrl_r[0][cmpbk_pkg::RES_BIT] && !ctrl_r[1][cmpbk_pkg::RES_BIT])
    else $error("result bit became writable");

  // ==========================================================================
  // Interrupt gating
  // ==========================================================================
  // Masked events must stay silent however many are pending
  a_irq_masked: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    irq_msk_r == 2'h0 |-> !irq_o)
    else $error("masked event raised interrupt");

  a_irq_sticky1: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    edge_evt[1] |=> irq_st_r[1])
    else $error("second event lost");

  a_pin_gate: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !pin_oe_o[1] |-> !pin_out_o[1])
    else $error("pin driven while disabled");

endmodule

// >>> dv/cmpbk_analog_model.sv
// Behavioural model of the analog comparator front end
`timescale 1ns/10ps
module cmpbk_analog_model (
  input  wire logic       clk_sys_i,    // System clock
  input  wire logic [1:0] level_i,      // Requested comparison outcome
  output logic      [1:0] raw_result_o  // Settled raw results
);
  // ==========================================================
  // Settling
  // ==========================================================
  // One cycle of settling: a real comparator never answers at once
  always @(posedge clk_sys_i) begin
    raw_result_o <= level_i;
  end
endmodule

// >>> dv/comparator_register_bank_tb.sv
// Self-checking testbench of the comparator register bank
`timescale 1ns/10ps
module comparator_register_bank_tb;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i  = 1'b0;
  logic [7:0]  addr_i    = 8'h00;
  logic [31:0] wdata_i   = 32'h0000_0000;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [1:0]  level     = 2'h0;
  logic [31:0] rdata_o, stat_m, got, ctl_m [2];
  logic [1:0]  raw, result_o, pin_out_o, pin_oe_o, enable_o, pos_sel_o;
  logic [3:0]  neg_sel_o;
  logic        freeze_o, idle_stop_o, irq_o;
  int          bad_count = 0, comparisons = 0, cycles = 0;

  cmpbk_analog_model u_model (.clk_sys_i(clk_sys_i), .level_i(level), .raw_result_o(raw));
  cmpbk_top dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .raw_result_i(raw), .result_o(result_o),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .enable_o(enable_o), .pos_sel_o(pos_sel_o),
    .neg_sel_o(neg_sel_o), .freeze_o(freeze_o), .idle_stop_o(idle_stop_o), .irq_o(irq_o));

  // ==========================================================
  // Clock and hang guard
  // ==========================================================
  initial forever #25 clk_sys_i = ~clk_sys_i;
  // Whole run needs well under 2000 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  // ==========================================================
  // Expectations and bus tasks
  // ==========================================================
  function automatic logic res_f(input int c);
    return ctl_m[c][15] & (level[c] ^ ctl_m[c][13]);
  endfunction
  function automatic logic [31:0] exp_f(input int c);
    if (c == 2) return stat_m | {30'h0, res_f(1), res_f(0)};
    return ctl_m[c] | {23'h0, res_f(c), 8'h00};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    int          c, k;
    logic [31:0] d, wm, m;
    void'($urandom(71));
    ctl_m[0] = cmpbk_pkg::CTRL_RST; ctl_m[1] = cmpbk_pkg::CTRL_RST; stat_m = 32'h0;
    repeat (6) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      rd(8'(j * 16), got); chk(got, exp_f(j));
    end
    // Random alias traffic; first four are all-ones corners on every alias of the first control
    for (int i = 0; i < 80; i++) begin
      c = $urandom % 3; k = $urandom % 4; d = $urandom;
      if (i < 4) begin c = 0; k = i; d = 32'hFFFF_FFFF; end
      wr(8'(c * 16 + k * 4), d);
      level <= 2'($urandom);
      wm = (c == 2) ? cmpbk_pkg::STAT_WMASK : cmpbk_pkg::CTRL_WMASK;
      m = (c == 2) ? stat_m : ctl_m[c];
      case (k)
        0: m = d & wm;
        1: m = m & ~(d & wm);
        2: m = m | (d & wm);
        default: m = m ^ (d & wm);
      endcase
      if (c == 2) stat_m = m; else ctl_m[c] = m;
      repeat (2) @(posedge clk_sys_i);
      rd(8'(c * 16), got); chk(got, exp_f(c));
      chk({30'h0, result_o}, {30'h0, res_f(1), res_f(0)});
      chk({28'h0, neg_sel_o}, {28'h0, ctl_m[1][1:0], ctl_m[0][1:0]});
      chk({30'h0, pos_sel_o}, {30'h0, ctl_m[1][4], ctl_m[0][4]});
      chk({28'h0, pin_oe_o, enable_o}, {28'h0, ctl_m[1][15] & ctl_m[1][14], ctl_m[0][15] & ctl_m[0][14],
        ctl_m[1][15], ctl_m[0][15]});
      chk({30'h0, freeze_o, idle_stop_o}, {30'h0, stat_m[14:13]});
      chk({30'h0, pin_out_o}, {30'h0, res_f(1) & ctl_m[1][14], res_f(0) & ctl_m[0][14]});
    end
    // Misaligned write ignored, unmapped read gives zero; alias reads not judged
    wr(8'h02, 32'h0000_FFFF);
    rd(8'h00, got); chk(got, exp_f(0));
    rd(8'h3C, got); chk(got, 32'h0);
    // Interrupt: rising result on comparator 0, then mask and clear
    wr(8'h10, 32'h0); ctl_m[1] = 32'h0;
    wr(8'h00, 32'h0000_80C0); ctl_m[0] = 32'h0000_80C0;
    level <= 2'h0;
    repeat (3) @(posedge clk_sys_i);
    wr(8'h34, 32'h1); wr(8'h30, 32'h3);
    #1 chk({31'h0, irq_o}, 32'h0);
    level <= 2'h1;
    repeat (4) @(posedge clk_sys_i);
    rd(8'h30, got); chk(got, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    wr(8'h34, 32'h0);
    #1 chk({31'h0, irq_o}, 32'h0);
    wr(8'h34, 32'h1); wr(8'h30, 32'h1);
    #1 chk({31'h0, irq_o}, 32'h0);
    rd(8'h30, got); chk(got, 32'h0);
    print_verdict();
  end
endmodule
